// >>> hw/adc_setup_and_cal_regs.sv
// setup pair registers, calibration selection and conversion start control
`include "adc_setup_defs.svh"

// Functional notes
// (R1) channel field 00..11 selects physical inputs one to four
// (R2) gain field selects amplifier gain 1 to 64; span is reference times A over gain
// (R3) span factor A is 2 with range bit 0, 1 with bit 1; bipolar doubles
// (R4) four-bit rate code picks output rate; scaling gives five-sixths
// (R5) controller programs only the ten listed rate codes
// (R6) rates scale linearly with master clock frequency
// (R7) first continuous and single conversions take longer than one period
// (R8) polarity field chooses bipolar or unipolar coding per setup
// (R9) with setup latch source, latch outputs follow setup field at command
// (R10) delay bit waits 1280 cycles, 1536 when scaled, else start immediately
// (R11) open-input bit enables current source on selected channel positive input
// (R12) with pointer source, pointer chooses calibration pair one to four
// (R13) with channel source, calibration pair follows the channel field
// (R14) one offset and one gain register per channel
// (R15) after reset conversions use gain 1.0 and offset 0.0
// (R16) offset top bit gives sign: 0 positive, 1 negative
// (R17) offset lsb weighs 1.835007966 times two to minus 24 of span
// (R18) offset magnitude is scaled through the gain value
// (R19) gain bits 29..0 weigh two to i minus 24; top two unused
// (R20) controller never writes gain above 40
// (R21) reset gain register has only bit 24 set
// (R22) four setup pair registers, odd setup high half, accessed as pair; code takes the odd setup from the low half
// (R23) rate scale bit scales rates and filter by five sixths
// (R24) with configuration latch source, latches follow configuration bits
// (R25) polarity 0 is bipolar, 1 is unipolar
// (R26) gain codes 000..110 map to 1..64; 111 unused
module adc_setup_and_cal_regs #(
   parameter int DELAY_NORMAL = `DELAY_CYCLES_NORMAL,
   parameter int DELAY_SCALED = `DELAY_CYCLES_SCALED
) (
   input  wire logic        sys_clk_in,
   input  wire logic        reset_n_in,
   input  wire logic        reg_wr_in,
   input  wire logic        reg_rd_in,
   input  wire logic [1:0]  reg_sel_in,
   input  wire logic [1:0]  reg_index_in,
   input  wire logic [31:0] reg_wdata_in,
   output logic      [31:0] reg_rdata_out,
   output logic             reg_rvalid_out,
   input  wire logic        conv_cmd_in,
   input  wire logic [2:0]  conv_setup_in,
   input  wire logic        rate_scale_sel_in,
   input  wire logic        ref_range_sel_in,
   input  wire logic        latch_source_sel_in,
   input  wire logic        cal_source_sel_in,
   input  wire logic [1:0]  cfg_latch_value_in,
   output logic             latch_out_0_out,
   output logic             latch_out_1_out,
   output logic [3:0]       open_current_en_out,
   output logic [1:0]       active_channel_out,
   output logic [6:0]       active_gain_out,
   output logic [3:0]       active_rate_code_out,
   output logic             active_unipolar_out,
   output logic             span_factor_two_out,
   output logic [1:0]       cal_pair_out,
   output logic [31:0]      active_offset_out,
   output logic [31:0]      active_gain_cal_out,
   output logic             conv_start_out,
   output logic             conv_busy_out
);

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   // pick one of two setups from a pair register
   function automatic adc_setup_pkg::setup_type pick_setup(input logic [31:0] pair, input logic low);
      logic [15:0] half;
      half = low ? pair[15:0] : pair[31:16];
      return adc_setup_pkg::setup_type'(half);
   endfunction

   // gain code to amplifier gain; unused code reads as zero
   function automatic logic [6:0] gain_of(input logic [2:0] code);
      logic [6:0] g;
      g = 7'h00;
      if (code != 3'h7) begin
         g = 7'(7'h01 << code);
      end
      return g;
   endfunction

   // ----------------------------------------
   // setup pair registers
   // ----------------------------------------
   logic [31:0] setup_pair_register_r [4];
   cal_reg_if   cal_bus ();

   // (R22) pair written whole
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         for (int i = 0; i < 4; i++) begin
            setup_pair_register_r[i] <= `SETUP_RESET;
         end
      end else if (reg_wr_in && reg_sel_in == `SEL_SETUP) begin
         setup_pair_register_r[reg_index_in] <= reg_wdata_in;
      end
   end

   // ----------------------------------------
   // calibration store
   // ----------------------------------------
   cal_reg_store u_store (
      .sys_clk_in (sys_clk_in),
      .reset_n_in (reset_n_in),
      .bus        (cal_bus)
   );

   // ----------------------------------------
   // conversion control
   // ----------------------------------------
   adc_setup_pkg::conv_state_type state_r;
   adc_setup_pkg::setup_type      cmd_setup;
   logic [10:0]                   settle_cnt_r;
   logic [1:0]                    cal_pick;
   logic                          fetch_r;
   logic                          rd_pend_r;
   logic                          rd_sel_gain_r;
   logic                          fetch_gain_r;

   assign cmd_setup = pick_setup(setup_pair_register_r[conv_setup_in[2:1]], conv_setup_in[0]);

   // (R12) pointer source
   // (R13) channel source
   assign cal_pick = cal_source_sel_in ? cmd_setup.cal_pair_pointer : cmd_setup.input_channel_sel;

   // (R23) scaled count, (R6) counts in master clock cycles
   // (R10) settle wait then start
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         state_r        <= adc_setup_pkg::CONV_IDLE;
         settle_cnt_r   <= 11'h000;
         conv_start_out <= 1'b0;
         conv_busy_out  <= 1'b0;
      end else begin
         conv_start_out <= 1'b0;
         unique case (state_r)
            adc_setup_pkg::CONV_IDLE: begin
               if (conv_cmd_in) begin
                  conv_busy_out <= 1'b1;
                  if (cmd_setup.settle_delay_en) begin
                     state_r      <= adc_setup_pkg::CONV_SETTLE;
                     settle_cnt_r <= 11'(rate_scale_sel_in ? DELAY_SCALED - 1 : DELAY_NORMAL - 1);
                  end else begin
                     state_r        <= adc_setup_pkg::CONV_RUN;
                     conv_start_out <= 1'b1;
                  end
               end
            end
            adc_setup_pkg::CONV_SETTLE: begin
               if (settle_cnt_r == 11'h000) begin
                  state_r        <= adc_setup_pkg::CONV_RUN;
                  conv_start_out <= 1'b1;
               end else begin
                  settle_cnt_r <= settle_cnt_r - 11'h001;
               end
            end
            adc_setup_pkg::CONV_RUN: begin
               // (R7) conversion timing lives downstream; release here
               state_r       <= adc_setup_pkg::CONV_IDLE;
               conv_busy_out <= 1'b0;
            end
         endcase
      end
   end

   // (R1) channel decode, (R2) gain decode, (R26) gain map, (R8) polarity
   // (R4) rate code latched, (R11) open current per channel, (R3) span factor
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         active_channel_out   <= 2'h0;
         active_gain_out      <= 7'h01;
         active_rate_code_out <= 4'h0;
         active_unipolar_out  <= 1'b0;
         span_factor_two_out  <= 1'b1;
         open_current_en_out  <= 4'h0;
         cal_pair_out         <= 2'h0;
      end else if (conv_cmd_in && state_r == adc_setup_pkg::CONV_IDLE) begin
         active_channel_out   <= cmd_setup.input_channel_sel;
         active_gain_out      <= gain_of(cmd_setup.amp_gain_code);
         active_rate_code_out <= cmd_setup.word_rate_code;
         // (R25) 0 bipolar, 1 unipolar
         active_unipolar_out  <= cmd_setup.unipolar;
         span_factor_two_out  <= ~ref_range_sel_in;
         open_current_en_out  <= cmd_setup.open_input_current_en ? 4'(4'h1 << cmd_setup.input_channel_sel) : 4'h0;
         cal_pair_out         <= cal_pick;
      end
   end

   // (R9) setup latch source, (R24) configuration latch source
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         latch_out_0_out <= 1'b0;
         latch_out_1_out <= 1'b0;
      end else if (conv_cmd_in && state_r == adc_setup_pkg::CONV_IDLE) begin
         latch_out_0_out <= latch_source_sel_in ? cfg_latch_value_in[1] : cmd_setup.setup_latch_value[1];
         latch_out_1_out <= latch_source_sel_in ? cfg_latch_value_in[0] : cmd_setup.setup_latch_value[0];
      end
   end

   // ----------------------------------------
   // calibration port and fetch
   // ----------------------------------------
   // (R14) per-channel store, (R19) (R16) used bits only
   always_comb begin
      cal_bus.wr_en   = reg_wr_in && (reg_sel_in == `SEL_OFFSET || reg_sel_in == `SEL_GAIN);
      cal_bus.wr_addr = {reg_sel_in == `SEL_GAIN, reg_index_in};
      cal_bus.wr_data = reg_wdata_in & ((reg_sel_in == `SEL_GAIN) ? `GAIN_USED_MASK : `OFFSET_USED_MASK);
      if (fetch_r) begin
         cal_bus.rd_addr = {fetch_gain_r, cal_pair_out};
      end else begin
         cal_bus.rd_addr = {reg_sel_in == `SEL_GAIN, reg_index_in};
      end
   end

   // fetch offset then gain after each command taken in idle; register reads during the fetch are dropped
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         fetch_r      <= 1'b0;
         fetch_gain_r <= 1'b0;
      end else if (conv_cmd_in && state_r == adc_setup_pkg::CONV_IDLE) begin
         fetch_r      <= 1'b1;
         fetch_gain_r <= 1'b0;
      end else if (fetch_r) begin
         fetch_r      <= ~fetch_gain_r;
         fetch_gain_r <= ~fetch_gain_r;
      end
   end

   // (R15) (R18) (R17) active pair forwarded to the scaling datapath
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         active_offset_out   <= `OFFSET_RESET;
         active_gain_cal_out <= `GAIN_RESET;
         rd_pend_r           <= 1'b0;
         rd_sel_gain_r       <= 1'b0;
      end else begin
         rd_pend_r     <= fetch_r;
         rd_sel_gain_r <= fetch_gain_r;
         if (rd_pend_r && !rd_sel_gain_r) begin
            active_offset_out <= cal_bus.rd_data;
         end
         if (rd_pend_r && rd_sel_gain_r) begin
            active_gain_cal_out <= cal_bus.rd_data;
         end
      end
   end

   // ----------------------------------------
   // register read path
   // ----------------------------------------
   logic        rd_cal_r;
   logic        rd_req_r;
   logic [31:0] rd_setup_r;

   // read outside a fetch answered two cycles after request, data held until next read
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         rd_cal_r       <= 1'b0;
         rd_req_r       <= 1'b0;
         rd_setup_r     <= 32'h00000000;
         reg_rvalid_out <= 1'b0;
         reg_rdata_out  <= 32'h00000000;
      end else begin
         rd_cal_r       <= reg_sel_in == `SEL_OFFSET || reg_sel_in == `SEL_GAIN;
         rd_setup_r     <= (reg_sel_in == `SEL_SETUP) ? setup_pair_register_r[reg_index_in] : 32'h00000000;
         rd_req_r       <= reg_rd_in && !fetch_r;
         reg_rvalid_out <= rd_req_r;
         if (rd_req_r && rd_cal_r) begin
            reg_rdata_out <= cal_bus.rd_data;
         end else if (rd_req_r) begin
            reg_rdata_out <= rd_setup_r;
         end
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   sequence settle_req;
      conv_cmd_in && state_r == adc_setup_pkg::CONV_IDLE && cmd_setup.settle_delay_en;
   endsequence

   sequence settle_counting;
      state_r == adc_setup_pkg::CONV_SETTLE && settle_cnt_r != 11'h000;
   endsequence

   chk_immediate_start: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // (R10)
      conv_cmd_in && state_r == adc_setup_pkg::CONV_IDLE && !cmd_setup.settle_delay_en |=> conv_start_out)
      else $error("start not immediate");
   chk_settle_wait: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // (R10)
      settle_req |=> state_r == adc_setup_pkg::CONV_SETTLE && !conv_start_out)
      else $error("start during settle");
   chk_settle_hold: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // (R10)
      settle_counting |=> state_r == adc_setup_pkg::CONV_SETTLE && !conv_start_out)
      else $error("settle cut short");
   chk_settle_end: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // (R10)
      state_r == adc_setup_pkg::CONV_SETTLE && settle_cnt_r == 11'h000 |=> conv_start_out)
      else $error("no start after settle");
   chk_channel_pick: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // (R13)
      conv_cmd_in && state_r == adc_setup_pkg::CONV_IDLE && !cal_source_sel_in
      |=> cal_pair_out == $past(cmd_setup.input_channel_sel))
      else $error("cal pair not channel");
   chk_pointer_pick: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // (R12)
      conv_cmd_in && state_r == adc_setup_pkg::CONV_IDLE && cal_source_sel_in
      |=> cal_pair_out == $past(cmd_setup.cal_pair_pointer))
      else $error("cal pair not pointer");
   chk_latch_cfg: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // (R24)
      conv_cmd_in && state_r == adc_setup_pkg::CONV_IDLE && latch_source_sel_in
      |=> latch_out_1_out == $past(cfg_latch_value_in[0]))
      else $error("latch not from config");
   chk_latch_setup: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // (R9)
      conv_cmd_in && state_r == adc_setup_pkg::CONV_IDLE && !latch_source_sel_in
      |=> latch_out_0_out == $past(cmd_setup.setup_latch_value[1]))
      else $error("latch not from setup");
   chk_open_current: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // (R11)
      $countones(open_current_en_out) <= 1)
      else $error("several current sources on");
   chk_gain_range: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // (R26)
      $changed(active_gain_out) |-> $countones(active_gain_out) <= 1)
      else $error("gain not power of two");
   chk_busy_refuse: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // (R10)
      conv_cmd_in && state_r != adc_setup_pkg::CONV_IDLE |=> $stable(active_channel_out) && $stable(cal_pair_out))
      else $error("command taken while busy");
   chk_span_factor: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // (R3)
      conv_cmd_in && state_r == adc_setup_pkg::CONV_IDLE |=> span_factor_two_out == !$past(ref_range_sel_in))
      else $error("span factor wrong");
   chk_unipolar_pick: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // (R8)
      conv_cmd_in && state_r == adc_setup_pkg::CONV_IDLE |=> active_unipolar_out == $past(cmd_setup.unipolar))
      else $error("polarity not from setup");
   chk_rate_pick: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // (R4)
      conv_cmd_in && state_r == adc_setup_pkg::CONV_IDLE |=> active_rate_code_out == $past(cmd_setup.word_rate_code))
      else $error("rate code not from setup");
   chk_read_answer: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // (R22)
      reg_rd_in && !fetch_r |-> ##2 reg_rvalid_out)
      else $error("read not answered");
   chk_gain_mask: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // (R19)
      cal_bus.wr_en && reg_sel_in == `SEL_GAIN |-> cal_bus.wr_data[31:30] == 2'h0)
      else $error("unused gain bits stored");

endmodule

// >>> hw/adc_setup_defs.svh
// constants for the setup and calibration register block
`ifndef ADC_SETUP_DEFS_SVH
`define ADC_SETUP_DEFS_SVH

// ----------------------------------------
// setup field positions (lower setup, upper adds 16)
// ----------------------------------------
`define SETUP_HALF_W        16
`define SETUP_CHAN_LSB      14
`define SETUP_GAIN_LSB      11
`define SETUP_RATE_LSB      7
`define SETUP_POL_BIT       6
`define SETUP_LATCH_LSB     4
`define SETUP_DELAY_BIT     3
`define SETUP_OPEN_BIT      2
`define SETUP_PTR_LSB       0

// ----------------------------------------
// register selects on the command port
// ----------------------------------------
`define SEL_SETUP           2'h0
`define SEL_OFFSET          2'h1
`define SEL_GAIN            2'h2

// ----------------------------------------
// reset values and timing counts
// ----------------------------------------
`define SETUP_RESET         32'h00000000
`define OFFSET_RESET        32'h00000000
`define GAIN_RESET          32'h01000000
`define GAIN_USED_MASK      32'h3FFFFFFF
`define OFFSET_USED_MASK    32'hFFFFFF00
`define DELAY_CYCLES_NORMAL 1280
`define DELAY_CYCLES_SCALED 1536

`endif

// >>> hw/adc_setup_pkg.sv
// types shared by the setup and calibration register block
package adc_setup_pkg;

   // ----------------------------------------
   // decoded setup
   // ----------------------------------------
   typedef struct packed {
      logic [1:0] input_channel_sel;
      logic [2:0] amp_gain_code;
      logic [3:0] word_rate_code;
      logic       unipolar;
      logic [1:0] setup_latch_value;
      logic       settle_delay_en;
      logic       open_input_current_en;
      logic [1:0] cal_pair_pointer;
   } setup_type;

   typedef enum logic [1:0] {
      CONV_IDLE,
      CONV_SETTLE,
      CONV_RUN
   } conv_state_type;

endpackage

// >>> hw/cal_reg_if.sv
// interface between the block and its calibration register store
interface cal_reg_if;
   logic        wr_en;
   logic [2:0]  wr_addr;
   logic [31:0] wr_data;
   logic [2:0]  rd_addr;
   logic [31:0] rd_data;

   modport ctrl  (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
   modport store (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface

// >>> hw/cal_reg_store.sv
// offset and gain registers, one pair per channel, registered read
`include "adc_setup_defs.svh"

module cal_reg_store (
   input  wire logic sys_clk_in,
   input  wire logic reset_n_in,
   cal_reg_if.store  bus
);

   // ----------------------------------------
   // storage: index 0..3 offsets, 4..7 gains
   // ----------------------------------------
   logic [31:0] mem_r [8];

   // (R21) reset loads unity gain, (R15) zero offset
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         for (int i = 0; i < 8; i++) begin
            mem_r[i] <= (i >= 4) ? `GAIN_RESET : `OFFSET_RESET;
         end
      end else if (bus.wr_en) begin
         mem_r[bus.wr_addr] <= bus.wr_data;
      end
   end

   // read data leaves through a register
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         bus.rd_data <= `OFFSET_RESET;
      end else begin
         bus.rd_data <= mem_r[bus.rd_addr];
      end
   end

endmodule

// >>> test/host_ctrl_model.sv
// controller-side model that issues register accesses and conversion commands
`include "adc_setup_defs.svh"

module host_ctrl_model (
   input  wire logic        sys_clk_in,
   output logic             reg_wr_out,
   output logic             reg_rd_out,
   output logic [1:0]       reg_sel_out,
   output logic [1:0]       reg_index_out,
   output logic [31:0]      reg_wdata_out,
   input  wire logic [31:0] reg_rdata_in,
   input  wire logic        reg_rvalid_in,
   output logic             conv_cmd_out,
   output logic [2:0]       conv_setup_out
);
   timeunit 1ns;
   timeprecision 1ps;

   // idle levels before the first request
   initial begin
      reg_wr_out = 1'b0;
      reg_rd_out = 1'b0;
      reg_sel_out = 2'h0;
      reg_index_out = 2'h0;
      reg_wdata_out = 32'h0;
      conv_cmd_out = 1'b0;
      conv_setup_out = 3'h0;
   end

   // only the ten listed rate codes
   function automatic logic [15:0] mk_setup(input logic [2:0] s, input int k);
      logic [3:0] rate [10];
      rate = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h8, 4'h9, 4'hA, 4'hB, 4'hC};
      return {s[1:0], s, rate[(s + k) % 10], s[0], s[2:1], s == 3'h5, s[1] ^ s[2], ~s[1:0]};
   endfunction

   // one register write; data lines show garbage once released
   task automatic wr(input logic [1:0] s, input logic [1:0] i, input logic [31:0] d);
      logic [31:0] v;
      v = d;
      // gain kept at or below 40
      if (s == `SEL_GAIN && (d & `GAIN_USED_MASK) > 32'h28000000) begin
         v = (d & 32'hC0000000) | 32'h28000000;
      end
      @(posedge sys_clk_in);
      reg_wr_out <= 1'b1;
      reg_sel_out <= s;
      reg_index_out <= i;
      reg_wdata_out <= v;
      @(posedge sys_clk_in);
      reg_wr_out <= 1'b0;
      reg_wdata_out <= ~v;
   endtask

   // one register read, select held until the answer
   task automatic rd(input logic [1:0] s, input logic [1:0] i, output logic [31:0] d, output logic ok);
      @(posedge sys_clk_in);
      reg_rd_out <= 1'b1;
      reg_sel_out <= s;
      reg_index_out <= i;
      @(posedge sys_clk_in);
      reg_rd_out <= 1'b0;
      ok = 1'b0;
      for (int n = 0; n < 4 && !ok; n++) begin
         @(posedge sys_clk_in);
         #1;
         ok = (reg_rvalid_in === 1'b1);
      end
      d = reg_rdata_in;
   endtask

   // one conversion command pulse
   task automatic cmd(input logic [2:0] s);
      @(posedge sys_clk_in);
      conv_cmd_out <= 1'b1;
      conv_setup_out <= s;
      @(posedge sys_clk_in);
      conv_cmd_out <= 1'b0;
   endtask
endmodule

// >>> test/tb.sv
// self-checking bench for the setup and calibration register block
`include "adc_setup_defs.svh"

module tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int DLY_N = 4;
   localparam int DLY_S = 5;

   logic        clk = 1'b0;
   logic        reset_n;
   logic        rate_scale, ref_range, latch_src, cal_src;
   logic        wr, rd, rvalid, cmd, latch0, latch1, uni, span2, start, busy;
   logic [1:0]  cfg_latch, sel, idx, act_ch, cal_pair;
   logic [2:0]  setup;
   logic [3:0]  open_en, act_rate;
   logic [6:0]  act_gain;
   logic [31:0] wdata, rdata, act_off, act_gcal;
   logic [31:0] off_e [4];
   logic [31:0] gain_e [4];
   int          n_errors = 0;
   int          n_compared = 0;

   always #10 clk = ~clk;

   host_ctrl_model host_ctrl_model_i (.sys_clk_in(clk), .reg_wr_out(wr), .reg_rd_out(rd),
      .reg_sel_out(sel), .reg_index_out(idx), .reg_wdata_out(wdata), .reg_rdata_in(rdata),
      .reg_rvalid_in(rvalid), .conv_cmd_out(cmd), .conv_setup_out(setup));

   adc_setup_and_cal_regs #(.DELAY_NORMAL(DLY_N), .DELAY_SCALED(DLY_S)) adc_setup_and_cal_regs_i (
      .sys_clk_in(clk), .reset_n_in(reset_n), .reg_wr_in(wr), .reg_rd_in(rd), .reg_sel_in(sel),
      .reg_index_in(idx), .reg_wdata_in(wdata), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
      .conv_cmd_in(cmd), .conv_setup_in(setup), .rate_scale_sel_in(rate_scale),
      .ref_range_sel_in(ref_range), .latch_source_sel_in(latch_src), .cal_source_sel_in(cal_src),
      .cfg_latch_value_in(cfg_latch), .latch_out_0_out(latch0), .latch_out_1_out(latch1),
      .open_current_en_out(open_en), .active_channel_out(act_ch), .active_gain_out(act_gain),
      .active_rate_code_out(act_rate), .active_unipolar_out(uni), .span_factor_two_out(span2),
      .cal_pair_out(cal_pair), .active_offset_out(act_off), .active_gain_cal_out(act_gcal),
      .conv_start_out(start), .conv_busy_out(busy));

   // compare one value and count it
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // report counts and verdict, then stop
   task automatic conclude();
      $display("compared %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic timeout(input string name);
      n_errors++;
      $display("MISMATCH %s expected response seen none", name);
      conclude();
   endtask

   task automatic rd_chk(input string name, input logic [1:0] s, input logic [1:0] i, input logic [31:0] e);
      logic [31:0] d;
      logic        ok;
      host_ctrl_model_i.rd(s, i, d, ok);
      if (!ok) begin
         timeout(name);
      end
      chk(name, d, e);
   endtask

   // command one setup and wait for the start pulse, returns cycles taken
   task automatic run_cmd(input logic [2:0] s, output int cnt);
      host_ctrl_model_i.cmd(s);
      cnt = 1;
      #1;
      while (start !== 1'b1 && cnt < 20) begin
         @(posedge clk);
         #1;
         cnt++;
      end
      if (start !== 1'b1) begin
         timeout("conv_start");
      end
   endtask

   initial begin
      logic [31:0] pair, gw, ow;
      logic [15:0] w;
      logic [1:0]  cp, lt;
      int          cnt;
      {reset_n, rate_scale, ref_range, latch_src, cal_src, cfg_latch} = '0;
      repeat (12) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      #1;
      chk("reset_outputs", {act_gain, span2, start, busy, latch0, latch1, open_en}, 16'h0300);
      chk("reset_gain_cal", act_gcal, 32'h01000000);
      chk("reset_offset", act_off, 32'h0);
      for (int c = 0; c < 4; c++) begin
         rd_chk("gain_reset", `SEL_GAIN, c[1:0], 32'h01000000);
         rd_chk("offset_reset", `SEL_OFFSET, c[1:0], 32'h0);
         rd_chk("setup_reset", `SEL_SETUP, c[1:0], 32'h0);
      end
      rd_chk("unmapped", 2'h3, 2'h0, 32'h0);
      for (int p = 0; p < 2; p++) begin
         @(posedge clk);
         rate_scale <= p[0];
         ref_range <= p[0];
         latch_src <= p[0];
         cal_src <= p[0];
         cfg_latch <= p[0] ? 2'h2 : 2'h1;
         for (int c = 0; c < 4; c++) begin
            gw = 32'hC0000055 | (32'h00800000 * (c + 1 + p));
            ow = 32'h012345FF ^ (c << 30) ^ (p << 16);
            gain_e[c] = gw & 32'h3FFFFFFF;
            off_e[c] = ow & 32'hFFFFFF00;
            pair = {host_ctrl_model_i.mk_setup(3'(2 * c), p), host_ctrl_model_i.mk_setup(3'(2 * c + 1), p)};
            host_ctrl_model_i.wr(`SEL_GAIN, c[1:0], gw);
            host_ctrl_model_i.wr(`SEL_OFFSET, c[1:0], ow);
            host_ctrl_model_i.wr(`SEL_SETUP, c[1:0], pair);
            rd_chk("gain_rw", `SEL_GAIN, c[1:0], gain_e[c]);
            rd_chk("offset_rw", `SEL_OFFSET, c[1:0], off_e[c]);
            rd_chk("setup_pair_rw", `SEL_SETUP, c[1:0], pair);
         end
         for (int s = 0; s < 8; s++) begin
            w = host_ctrl_model_i.mk_setup(3'(s), p);
            cp = p[0] ? w[1:0] : w[15:14];
            lt = p[0] ? cfg_latch : w[5:4];
            run_cmd(3'(s), cnt);
            chk("start_latency", cnt, !w[3] ? 1 : (p[0] ? DLY_S : DLY_N) + 1);
            chk("channel", act_ch, w[15:14]);
            chk("gain", act_gain, w[13:11] == 3'h7 ? 7'h0 : 7'h1 << w[13:11]);
            chk("rate_code", act_rate, w[10:7]);
            chk("unipolar", uni, w[6]);
            chk("latches", {latch0, latch1}, lt);
            chk("open_current", open_en, w[2] ? 4'h1 << w[15:14] : 4'h0);
            chk("cal_pair", cal_pair, cp);
            chk("span_factor", span2, !p[0]);
            for (int n = 0; n < 20 && busy !== 1'b0; n++) begin
               @(posedge clk);
               #1;
            end
            if (busy !== 1'b0) begin
               timeout("busy_release");
            end
            repeat (4) @(posedge clk);
            #1;
            chk("cal_offset", act_off, off_e[cp]);
            chk("cal_gain", act_gcal, gain_e[cp]);
         end
      end
      // a command during the settle wait is ignored
      host_ctrl_model_i.cmd(3'h5);
      host_ctrl_model_i.cmd(3'h0);
      run_cmd(3'h5, cnt);
      chk("busy_refusal", act_ch, 2'h1);
      conclude();
   end
endmodule
